// File: hw/acc_ctrl.sv
// Purpose: Calibration sequencing, full-scale choice and output edge control
// Assumes: hclk 20 MHz; input sample clock arrives as a pin and is sampled here
// Notes: Release of hresetn stands for the application of power
//
// Local design decisions: register access over AHB-Lite and the register offsets.
module acc_ctrl
    import acc_pkg::*;
#(
    parameter logic [23:0] POR_SHORT_CYCLES = 24'd16384,
    parameter logic [23:0] POR_LONG_CYCLES = 24'd1048576
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sample_clock,
    input wire logic calibrate_request,
    input wire logic full_shutdown,
    input wire logic calibration_delay_select,
    input wire logic output_edge_select,
    input wire logic full_scale_select,
    input wire logic [7:0] conv_data,
    output logic calibration_running,
    output logic analog_off,
    output logic [9:0] full_scale_mv,
    output logic output_data_clock,
    output logic [7:0] data_out,
    output logic irq
);
    logic [5:0] sync1, sync2;
    logic clk_d;
    logic tick;
    logic req_s, shut_s, dly_s, edge_s, fs_s;
    logic low_done, high_done, high_done_d, armed, fire;
    logic [1:0] boot_cnt;
    logic boot_done, strap_skip, clk_seen;
    logic [23:0] por_cnt;
    logic [23:0] por_target;
    logic por_fire;
    logic [11:0] cal_cnt;
    logic cal_end;
    acc_state_t state;
    logic ext_mode;
    logic [9:0] range_mv;
    logic [ACC_EV_W-1:0] int_status, int_en, ev;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic ap_sel;
    logic [31:0] next_rdata;

    // Two-stage synchroniser for the sample clock and the five control pins (not conv_data), plus input clock history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            clk_d <= 1'b0;
        end else begin
            sync1 <= {sample_clock, calibrate_request, full_shutdown,
                      calibration_delay_select, output_edge_select, full_scale_select};
            sync2 <= sync1;
            clk_d <= sync2[5];
        end
    end
    assign {req_s, shut_s, dly_s, edge_s, fs_s} = sync2[4:0];
    // Edges count only after boot, so a clock high at reset release fakes none
    assign tick = sync2[5] && !clk_d && boot_done;

    // Low and high phase qualifiers of the request pin
    acc_qual u_low (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .level_ok(!req_s),
        .done(low_done)
    );
    acc_qual u_high (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .level_ok(req_s),
        .done(high_done)
    );

    // Arm on a qualified low phase, disarm on a short one, fire on a qualified high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed <= 1'b0;
            high_done_d <= 1'b0;
        end else begin
            high_done_d <= high_done;
            if (low_done) begin
                armed <= 1'b1;
            end else if (fire || !req_s) begin
                armed <= 1'b0;
            end
        end
    end
    assign fire = armed && high_done && !high_done_d;

    // Strap capture after synchroniser settles, and clock-seen flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_cnt <= 2'h0;
            boot_done <= 1'b0;
            strap_skip <= 1'b0;
            clk_seen <= 1'b0;
        end else begin
            if (!boot_done) begin
                boot_cnt <= boot_cnt + 2'h1;
            end
            if (!boot_done && boot_cnt == ACC_BOOT_CYCLES) begin
                boot_done <= 1'b1;
                strap_skip <= req_s;
            end
            if (tick) begin
                clk_seen <= 1'b1;
            end
        end
    end

    // Power-on delay counts input clock edges, so a late clock changes nothing
    assign por_target = (ext_mode || !dly_s) ? POR_SHORT_CYCLES : POR_LONG_CYCLES;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            por_cnt <= 24'h000000;
        end else if (state == ACC_POR_WAIT && tick && !shut_s && por_cnt < por_target) begin
            por_cnt <= por_cnt + 24'h000001;
        end
    end
    assign por_fire = boot_done && !strap_skip && por_cnt >= por_target;

    // Calibration length counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_cnt <= 12'h000;
        end else if (state != ACC_CAL) begin
            cal_cnt <= 12'h000;
        end else if (tick) begin
            cal_cnt <= cal_cnt + 12'h001;
        end
    end
    assign cal_end = tick && cal_cnt == ACC_CAL_LEN_CYCLES - 12'h001;

    // Sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ACC_POR_WAIT;
        end else begin
            unique case (state)
                ACC_POR_WAIT: begin
                    if (boot_done && strap_skip) begin
                        state <= ACC_IDLE;
                    end else if (por_fire) begin
                        state <= ACC_CAL;
                    end
                end
                ACC_IDLE: begin
                    if (shut_s) begin
                        state <= ACC_DOWN;
                    end else if (fire) begin
                        state <= ACC_CAL;
                    end
                end
                ACC_CAL: begin
                    if (cal_end) begin
                        state <= shut_s ? ACC_DOWN : ACC_IDLE;
                    end
                end
                ACC_DOWN: begin
                    if (!shut_s) begin
                        state <= ACC_IDLE; // Requests here are dropped
                    end
                end
                default: state <= ACC_POR_WAIT;
            endcase
        end
    end

    // Status outputs
    assign calibration_running = (state == ACC_CAL);
    assign analog_off = (state == ACC_DOWN) || (state == ACC_POR_WAIT && !clk_seen);
    assign full_scale_mv = ext_mode ? range_mv : (fs_s ? ACC_FS_HIGH_MV : ACC_FS_LOW_MV);

    // Output data clock at half the input rate, data moved on the chosen edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_data_clock <= 1'b0;
            data_out <= 8'h00;
        end else if (tick) begin
            output_data_clock <= !output_data_clock;
            if (edge_s == !output_data_clock) begin
                data_out <= conv_data;
            end
        end
    end

    // Events
    assign ev[ACC_EV_CAL_START] = (state == ACC_IDLE && fire && !shut_s) ||
                                  (state == ACC_POR_WAIT && por_fire);
    assign ev[ACC_EV_CAL_DONE] = (state == ACC_CAL) && cal_end;
    assign ev[ACC_EV_REQ_IGNORED] = (state == ACC_DOWN) && fire;

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_sel = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr <= ap_sel && hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // Writable registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_mode <= ACC_CTRL_EXT_RST;
            range_mv <= ACC_RANGE_RST;
            int_en <= ACC_EV_RST;
        end else if (dp_wr) begin
            if (dp_addr == ACC_OFS_CTRL) begin
                ext_mode <= hwdata[ACC_CTRL_EXT_BIT];
            end
            if (dp_addr == ACC_OFS_RANGE) begin
                if (hwdata[9:0] < ACC_FS_EXT_MIN_MV) begin
                    range_mv <= ACC_FS_EXT_MIN_MV;
                end else if (hwdata[9:0] > ACC_FS_EXT_MAX_MV) begin
                    range_mv <= ACC_FS_EXT_MAX_MV;
                end else begin
                    range_mv <= hwdata[9:0];
                end
            end
            if (dp_addr == ACC_OFS_INT_EN) begin
                int_en <= hwdata[ACC_EV_W-1:0];
            end
        end
    end

    // Sticky status, a new event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status <= ACC_EV_RST;
        end else begin
            if (dp_wr && dp_addr == ACC_OFS_INT_CLR) begin
                int_status <= (int_status & ~hwdata[ACC_EV_W-1:0]) | ev;
            end else begin
                int_status <= int_status | ev;
            end
        end
    end
    assign irq = |(int_status & int_en);

    // Read data registered in the address phase
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (haddr[7:0])
            ACC_OFS_CTRL: next_rdata[ACC_CTRL_EXT_BIT] = ext_mode;
            ACC_OFS_RANGE: next_rdata[9:0] = range_mv;
            ACC_OFS_STATE: begin
                next_rdata[3:0] = state;
                next_rdata[ACC_ST_RUN_BIT] = calibration_running;
                next_rdata[ACC_ST_AOFF_BIT] = analog_off;
                next_rdata[ACC_ST_SKIP_BIT] = strap_skip;
                next_rdata[ACC_ST_FS_LSB +: 10] = full_scale_mv;
            end
            ACC_OFS_INT_STATUS: next_rdata[ACC_EV_W-1:0] = int_status;
            ACC_OFS_INT_EN: next_rdata[ACC_EV_W-1:0] = int_en;
            default: next_rdata = 32'h00000000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ap_sel && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_idle_fire;
        state == ACC_IDLE && fire && !shut_s;
    endsequence
    sequence s_cal_entered;
        state == ACC_CAL && cal_cnt == 12'h000;
    endsequence

    AST_RUN_FOLLOWS_STATE: assert property (calibration_running == (state == ACC_CAL))
        else $error("calibration_running disagrees with state");
    AST_FIRE_STARTS_CAL: assert property (s_idle_fire |=> s_cal_entered)
        else $error("qualified request did not start calibration");
    AST_STRAP_SKIPS: assert property ((state == ACC_POR_WAIT && boot_done && strap_skip)
        |=> state == ACC_IDLE)
        else $error("strapped request did not skip power-on calibration");
    AST_START_NEEDS_CAUSE: assert property ($rose(state == ACC_CAL) |->
        $past(state == ACC_IDLE && fire) || $past(state == ACC_POR_WAIT && por_fire))
        else $error("calibration started without a qualified cause");
    AST_DELAY_HELD: assert property ((state == ACC_POR_WAIT && shut_s) |=> $stable(por_cnt))
        else $error("power-on delay counted during shutdown");
    AST_EXT_SHORT: assert property (ext_mode |-> por_target == POR_SHORT_CYCLES)
        else $error("extended mode did not use short delay");
    AST_CAL_FINISHES: assert property ((state == ACC_CAL && !cal_end) |=> state == ACC_CAL)
        else $error("calibration left before its end");
    AST_DOWN_NO_CAL: assert property (state == ACC_DOWN |=> state != ACC_CAL)
        else $error("calibration started from shutdown");
    AST_DATA_EDGE: assert property ($changed(data_out) |->
        (output_data_clock != $past(output_data_clock)) && (output_data_clock == $past(edge_s)))
        else $error("output data changed on the wrong clock edge");
    AST_RANGE_NORMAL: assert property (!ext_mode |->
        full_scale_mv == (fs_s ? ACC_FS_HIGH_MV : ACC_FS_LOW_MV))
        else $error("normal-mode full-scale range wrong");
    AST_ANALOG_OFF: assert property ((state == ACC_POR_WAIT && !clk_seen) |-> analog_off)
        else $error("analog powered before input clock started");
    AST_CAL_LENGTH: assert property (s_cal_entered |=> (state == ACC_CAL)[*8])
        else $error("calibration shorter than expected");
endmodule // acc_ctrl

// File: hw/acc_pkg.sv
// Purpose: Shared constants and types of the calibration and output edge controller
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Cycle counts here are counted in input sample clock periods, except ACC_BOOT_CYCLES in hclk cycles
package acc_pkg;
    // Register byte offsets
    localparam logic [7:0] ACC_OFS_CTRL = 8'h00;
    localparam logic [7:0] ACC_OFS_RANGE = 8'h04;
    localparam logic [7:0] ACC_OFS_STATE = 8'h08;
    localparam logic [7:0] ACC_OFS_INT_STATUS = 8'h0C;
    localparam logic [7:0] ACC_OFS_INT_EN = 8'h10;
    localparam logic [7:0] ACC_OFS_INT_CLR = 8'h14;
    // Control field positions and reset values
    localparam int ACC_CTRL_EXT_BIT = 0;
    localparam logic ACC_CTRL_EXT_RST = 1'b0;
    localparam logic [9:0] ACC_RANGE_RST = 10'h2BC;
    // Event bit positions
    localparam int ACC_EV_CAL_START = 0;
    localparam int ACC_EV_CAL_DONE = 1;
    localparam int ACC_EV_REQ_IGNORED = 2;
    localparam int ACC_EV_W = 3;
    localparam logic [ACC_EV_W-1:0] ACC_EV_RST = 3'h0;
    // State register field positions
    localparam int ACC_ST_RUN_BIT = 4;
    localparam int ACC_ST_AOFF_BIT = 5;
    localparam int ACC_ST_SKIP_BIT = 6;
    localparam int ACC_ST_FS_LSB = 16;
    // Full-scale ranges in millivolts peak to peak
    localparam logic [9:0] ACC_FS_LOW_MV = 10'd650;
    localparam logic [9:0] ACC_FS_HIGH_MV = 10'd870;
    localparam logic [9:0] ACC_FS_EXT_MIN_MV = 10'd560;
    localparam logic [9:0] ACC_FS_EXT_MAX_MV = 10'd840;
    // Timing counts in input clock cycles, except ACC_BOOT_CYCLES in hclk cycles
    localparam logic [6:0] ACC_QUAL_CYCLES = 7'd80;
    localparam logic [11:0] ACC_CAL_LEN_CYCLES = 12'd1400;
    localparam logic [1:0] ACC_BOOT_CYCLES = 2'h3;
    // Controller states
    typedef enum logic [3:0] {
        ACC_POR_WAIT = 4'b0001,
        ACC_IDLE = 4'b0010,
        ACC_CAL = 4'b0100,
        ACC_DOWN = 4'b1000
    } acc_state_t;
endpackage

// File: hw/acc_qual.sv
// Purpose: Counts input clock cycles for which a level has held unbroken
// Assumes: tick is a one-cycle pulse per input clock edge, level is synchronised
// Notes: done saturates until the level breaks
module acc_qual
    import acc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic level_ok,
    output logic done
);
    logic [6:0] cnt;

    // Restart on any break of the level, so glitches never qualify
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 7'h00;
        end else if (!level_ok) begin
            cnt <= 7'h00;
        end else if (tick && cnt != ACC_QUAL_CYCLES) begin
            cnt <= cnt + 7'h01;
        end
    end

    // Done already in the cycle of the last edge, so a level that breaks right after counts
    assign done = level_ok && (cnt == ACC_QUAL_CYCLES || (tick && cnt == ACC_QUAL_CYCLES - 7'h01));
endmodule // acc_qual

// File: dv/acc_host_model.sv
// Purpose: External controller model: input sample clock and calibration request pin
// Assumes: Driven from hclk rising edges by non-blocking assignment
// Notes: Sample clock period is 8 hclk cycles, halted while clk_run is low
module acc_host_model (
    input wire logic hclk,
    input wire logic clk_run,
    output logic sample_clock,
    output logic calibrate_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div;
    initial begin
        sample_clock = 1'b0;
        calibrate_request = 1'b0;
        div = 2'h0;
    end
    // Divide hclk by eight while running
    always @(posedge hclk) begin
        if (clk_run) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                sample_clock <= ~sample_clock;
            end
        end
    end
    // Hold request level for n sample clock rising edges
    task automatic hold_req(input logic lvl, input int n);
        @(posedge hclk);
        calibrate_request <= lvl;
        repeat (n) @(posedge sample_clock);
    endtask
    // Low phase then high phase; used only in normal mode, well after power-up
    task automatic full_req(input int lo, input int hi);
        hold_req(1'b0, lo);
        hold_req(1'b1, hi);
    endtask
endmodule // acc_host_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench of the calibration and output edge controller
// Assumes: Power-on delays shortened to 20 and 40 sample cycles
// Notes: Times are counted in sample clock rising edges seen by the bench
module tb_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic ext; logic fs; logic edg;
        logic [9:0] rng; logic [9:0] mv;} acc_row_t;
    acc_row_t rows [5] = '{
        '{1'b0, 1'b0, 1'b0, 10'h000, ACC_FS_LOW_MV},
        '{1'b0, 1'b1, 1'b1, 10'h000, ACC_FS_HIGH_MV},
        '{1'b1, 1'b0, 1'b1, 10'h258, 10'h258},
        '{1'b1, 1'b1, 1'b0, 10'h1F4, ACC_FS_EXT_MIN_MV},
        '{1'b1, 1'b0, 1'b1, 10'h384, ACC_FS_EXT_MAX_MV}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic full_shutdown = 1'b1;
    logic calibration_delay_select = 1'b0;
    logic output_edge_select = 1'b0;
    logic full_scale_select = 1'b0;
    logic [7:0] conv_data = 8'h00;
    logic clk_run = 1'b0;
    logic hreadyout, hresp, sample_clock, calibrate_request, calibration_running;
    logic analog_off, output_data_clock, irq;
    logic [31:0] hrdata;
    logic [9:0] full_scale_mv;
    logic [7:0] data_out;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int sclk_n = 0;
    int cal_starts = 0;

    acc_ctrl #(.POR_SHORT_CYCLES(24'd20), .POR_LONG_CYCLES(24'd40)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_clock(sample_clock),
        .calibrate_request(calibrate_request), .full_shutdown(full_shutdown),
        .calibration_delay_select(calibration_delay_select),
        .output_edge_select(output_edge_select), .full_scale_select(full_scale_select),
        .conv_data(conv_data), .calibration_running(calibration_running),
        .analog_off(analog_off), .full_scale_mv(full_scale_mv),
        .output_data_clock(output_data_clock), .data_out(data_out), .irq(irq));
    acc_host_model u_host (.hclk(hclk), .clk_run(clk_run), .sample_clock(sample_clock),
        .calibrate_request(calibrate_request));

    // Clock, changing converter word, edge and start counters, timeout
    always #25 hclk = ~hclk;
    always @(posedge hclk) conv_data <= conv_data + 8'h01;
    always @(posedge sample_clock) sclk_n++;
    always @(posedge calibration_running) cal_starts++;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_win(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // One single AHB-Lite transfer, entered right after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check_val(what, e, x & m);
    endtask
    // Wait for calibration_running to reach lvl, return sample edges elapsed
    task automatic wait_run(input logic lvl, output int n);
        int s0;
        s0 = sclk_n;
        while (calibration_running !== lvl) @(posedge hclk);
        n = sclk_n - s0;
    endtask
    // Valid request; no start before the 80th high edge
    task automatic req_and_start(output int n);
        int c0;
        c0 = cal_starts;
        u_host.full_req(80, 79);
        check_win("early start", c0, c0, cal_starts);
        u_host.hold_req(1'b1, 1);
        wait_run(1'b1, n);
    endtask
    // Every data_out change lands as output_data_clock reaches lvl
    task automatic edge_watch(input logic lvl);
        logic [7:0] prev;
        prev = data_out;
        repeat (40) begin
            @(negedge hclk);
            if (data_out !== prev) begin
                check_val("data edge", {31'h0, lvl}, {31'h0, output_data_clock});
            end
            prev = data_out;
        end
        @(posedge hclk);
    endtask
    task automatic do_reset(input logic strap, input logic dly);
        hresetn <= 1'b0;
        full_shutdown <= 1'b0;
        calibration_delay_select <= dly;
        u_host.hold_req(strap, 0);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    initial begin
        int n;
        int c0;
        // Power-up with shutdown held and the sample clock absent
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        check_val("analog_off", 32'h1, {31'h0, analog_off});
        clk_run <= 1'b1;
        repeat (60) @(posedge sample_clock);
        check_win("cal in shutdown", 0, 0, cal_starts);
        check_val("analog_on", 32'h0, {31'h0, analog_off});
        check_val("hresp", 32'h0, {31'h0, hresp});
        rd_chk(ACC_OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
        rd_chk(ACC_OFS_RANGE, 32'h3FF, {22'h0, ACC_RANGE_RST}, "range reset");
        rd_chk(ACC_OFS_INT_EN, 32'hFFFFFFFF, 32'h0, "int_en reset");
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
        rd_chk(ACC_OFS_STATE, 32'hF, 32'h1, "state por");
        full_shutdown <= 1'b0;
        wait_run(1'b1, n);
        check_win("por delay short", 19, 21, n);
        wait_run(1'b0, n);
        check_win("cal length", 1399, 1401, n);
        @(posedge hclk);
        rd_chk(ACC_OFS_INT_STATUS, 32'h7, 32'h3, "events");
        check_val("irq masked", 32'h0, {31'h0, irq});
        wr(ACC_OFS_INT_EN, 32'h3);
        @(posedge hclk);
        check_val("irq set", 32'h1, {31'h0, irq});
        wr(ACC_OFS_INT_CLR, 32'h3);
        @(posedge hclk);
        check_val("irq clear", 32'h0, {31'h0, irq});
        rd_chk(ACC_OFS_INT_STATUS, 32'h7, 32'h0, "events cleared");
        // Range and output edge table
        foreach (rows[i]) begin
            full_scale_select <= rows[i].fs;
            output_edge_select <= rows[i].edg;
            wr(ACC_OFS_RANGE, {22'h0, rows[i].rng});
            wr(ACC_OFS_CTRL, {31'h0, rows[i].ext});
            repeat (2) @(posedge sample_clock);
            check_val("full_scale_mv", {22'h0, rows[i].mv}, {22'h0, full_scale_mv});
            edge_watch(rows[i].edg);
        end
        wr(ACC_OFS_CTRL, 32'h0);
        // Short phases and broken high phase never start calibration
        c0 = cal_starts;
        u_host.hold_req(1'b1, 5);
        u_host.full_req(79, 100);
        u_host.full_req(80, 79);
        u_host.hold_req(1'b0, 5);
        check_win("glitch start", c0, c0, cal_starts);
        req_and_start(n);
        check_win("req to start", 0, 1, n);
        // Shutdown in mid-calibration waits for the end
        repeat (200) @(posedge sample_clock);
        full_shutdown <= 1'b1;
        wait_run(1'b0, n);
        check_win("cal with shutdown", 1199, 1201, n);
        @(posedge hclk);
        rd_chk(ACC_OFS_STATE, 32'h3F, 32'h28, "state down");
        c0 = cal_starts;
        u_host.full_req(80, 90);
        check_win("req in shutdown", c0, c0, cal_starts);
        rd_chk(ACC_OFS_INT_STATUS, 32'h4, 32'h4, "ignored event");
        // Request high at power-up skips calibration until a full request
        do_reset(1'b1, 1'b0);
        c0 = cal_starts;
        repeat (60) @(posedge sample_clock);
        check_win("strap skip", c0, c0, cal_starts);
        rd_chk(ACC_OFS_STATE, 32'h4F, 32'h42, "state strap");
        req_and_start(n);
        check_win("strap then req", 0, 1, n);
        // Extended mode ignores long delay select
        do_reset(1'b0, 1'b1);
        wr(ACC_OFS_CTRL, 32'h1);
        wait_run(1'b1, n);
        check_win("por delay ext", 18, 21, n);
        do_reset(1'b0, 1'b1);
        wait_run(1'b1, n);
        check_win("por delay long", 38, 41, n);
        give_verdict();
    end
endmodule // tb_top
